// ---- logic/apcl_pkg.sv ----
package apcl_pkg;
	// byte register map, per-channel offsets packed with channel 0 lowest
	localparam logic [2:0][7:0] OFS_OUT_MODE = {8'h07, 8'h06, 8'h05};
	localparam logic [7:0] OFS_ROUTING = 8'h34;
	localparam logic [2:0][7:0] OFS_TGT_HI = {8'h39, 8'h37, 8'h35};
	localparam logic [2:0][7:0] OFS_TGT_LO = {8'h3A, 8'h38, 8'h36};
	localparam logic [2:0][7:0] OFS_LP_HI = {8'h3F, 8'h3D, 8'h3B};
	localparam logic [2:0][7:0] OFS_LP_LO = {8'h40, 8'h3E, 8'h3C};
	localparam logic [2:0][7:0] OFS_INTV = {8'h41, 8'h44, 8'h47};
	localparam logic [2:0][7:0] OFS_STEPS = {8'h42, 8'h45, 8'h48};
	localparam logic [2:0][7:0] OFS_DECIM = {8'h43, 8'h46, 8'h49};
	localparam logic [2:0][7:0] OFS_CODE_HI = {8'h18, 8'h14, 8'h10};
	localparam logic [2:0][7:0] OFS_CODE_LO = {8'h19, 8'h15, 8'h11};
	localparam logic [7:0] OFS_SETUP = 8'h4A;
	localparam logic [7:0] OFS_MISC = 8'h4B;
	localparam logic [7:0] OFS_STROBE = 8'h4C;
	localparam logic [2:0][7:0] OFS_RB_HI = {8'h54, 8'h52, 8'h50};
	localparam logic [2:0][7:0] OFS_RB_LO = {8'h55, 8'h53, 8'h51};
	// field positions
	localparam int OUT_MODE_CLOSED = 7;
	localparam int ROUTING_LOOP_SEL = 6;
	localparam int DECIM_FREEZE = 0;
	localparam int DECIM_DELAY_LSB = 1;
	localparam int DECIM_FACTOR_LSB = 3;
	localparam int DECIM_WAIT_LSB = 5;
	localparam int STEPS_INIT_LSB = 0;
	localparam int STEPS_START_LSB = 2;
	localparam int STEPS_MID_LSB = 4;
	localparam int STEPS_DIV_LSB = 6;
	localparam int INTV_INIT_LSB = 0;
	localparam int INTV_MID_LSB = 2;
	localparam int INTV_MIN_LSB = 4;
	localparam int INTV_DDLY_LSB = 6;
	localparam int SETUP_SINK = 4;
	localparam int SETUP_RATIO4 = 5;
	localparam int MISC_INVERT = 4;
	localparam int MISC_PIN_LSB = 5;
	localparam int STROBE_RB = 1;
	localparam logic [1:0] PIN_MODE_LOW_POWER = 2'h2;
	localparam logic [1:0] ROUTE_NONE = 2'h3;
	localparam logic [1:0] START_ZERO = 2'h0;
	localparam logic [1:0] START_HOST = 2'h1;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// target scale: 3.25 mA full scale, 390 nA per code, 13-bit code
	localparam int TARGET_FS_NA = 3250000;
	localparam int TARGET_STEP_NA = 390;
	localparam logic [12:0] TARGET_MAX = 13'h1FFF;
	localparam logic [9:0] DAC_MAX = 10'h3FF;
	// timing at 125 MHz
	localparam int CLK_PERIOD_PS = 8000;
	localparam int DELAY_UNIT_NS = 1000;
	localparam int DELAY_UNIT_CYC = (DELAY_UNIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int INTV_UNIT_CYC = 4;
	localparam int EDGE_SPACING_NS = 500;
	localparam logic [3:0] PHASE_STEPS = 4'h8;
	localparam logic [1:0] PHASE_INIT = 2'h0;
	localparam logic [1:0] PHASE_MID = 2'h1;
	localparam logic [1:0] PHASE_MIN = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN} apcl_st_type;

	typedef struct packed {
		logic [2:0][7:0] out_mode;
		logic [7:0] routing;
		logic [2:0][12:0] target;
		logic [2:0][12:0] target_lp;
		logic [2:0][7:0] intv;
		logic [2:0][7:0] steps;
		logic [2:0][7:0] decim;
		logic [2:0][9:0] host_code;
		logic [7:0] setup;
		logic [7:0] misc;
		logic [2:0][9:0] dac;
		logic [2:0][9:0] readback;
		logic [2:0] on_prev;
		logic [1:0] trk;
		apcl_st_type st;
		logic [1:0] phase;
		logic [3:0] nstep;
		logic [15:0] timer;
		logic [12:0] tgt_act;
		logic [1:0] mon_sel;
		logic [7:0] rdata;
	} apcl_state_type;

	// saturating step of a drive code
	function automatic logic [9:0] apcl_step(input logic [9:0] code, input logic [4:0] sz,
		input logic up);
		logic [10:0] t;
		t = 11'h000;
		if (up) begin
			t = {1'b0, code} + {6'h00, sz};
			apcl_step = t[10] ? DAC_MAX : t[9:0];
		end else begin
			apcl_step = (code > {5'h00, sz}) ? code - {5'h00, sz} : 10'h000;
		end
	endfunction : apcl_step

	// interval length in cycles: base length stretched by divider and decimation
	function automatic logic [15:0] apcl_period(input logic [1:0] len, input logic [1:0] div,
		input logic [1:0] dec, input logic [1:0] wt);
		logic [15:0] p;
		p = 16'(({14'h0000, len} + 16'h0001) * INTV_UNIT_CYC);
		p = p << div;
		p = p << dec;
		apcl_period = p + {14'h0000, wt};
	endfunction : apcl_period
endpackage : apcl_pkg

// ---- logic/apcl_loop.sv ----
`timescale 1ns/1ps
// Overview of operation
// - three 13-bit targets, 390 nA per code
// - loop disabled channel drives host code
// - freeze bit holds that channel's drive code
// - rising light-on activates target, routes monitor
// - 2-bit routing per output, 00 is input 0
// - below target raises, above target lowers
// - invert bit flips the correction sign
// - two or more lights on suspends updates
// - most recently risen channel is tracked
// - strobe captures drive codes into readback
// - low-power pin mode picks alternate target
// - sink detector select, 1:1 or 4:1 mirror
// - start current: zero, host, or previous
// - turn-on delay before any adjustment
// - routing bit 6 set selects continuous loop
// - output mode bit 7 selects closed loop
// - interval register sets step interval lengths
// - steps register sets sizes, start, divider
// - decimation slows mid/min, wait states hold
// - target split across high and low bytes
// - loop-select cleared means open loop on host code
module apcl_loop
	import apcl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic reg_wr, // one-cycle write strobe
	input wire logic reg_rd, // one-cycle read strobe
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [2:0] channel_light_on,
	input wire logic low_power_select_pin,
	input wire logic [2:0][12:0] monitor_level, // digitised monitor inputs 0..2
	output logic [2:0][9:0] drive_code,
	output logic [12:0] target_active,
	output logic [1:0] monitor_select
);
	apcl_state_type s_q; // whole registered state
	apcl_state_type s_d; // next state

	// channel is under continuous closed-loop control
	function automatic logic closed(input apcl_state_type s, input logic [1:0] c);
		closed = s.out_mode[c][OUT_MODE_CLOSED] && s.misc[c]
			&& s.routing[ROUTING_LOOP_SEL]
			&& (s.routing[2*c +: 2] != ROUTE_NONE);
	endfunction : closed

	logic [2:0] rise; // rising edges of the light-on pins
	logic many_on; // more than one light on
	logic [12:0] mon_val; // routed, scaled monitor value
	logic [9:0] trk_dac; // drive code of the tracked channel
	logic frozen; // tracked channel frozen

	// edge detect and helpers shared with the checks
	always_comb begin
		rise = channel_light_on & ~s_q.on_prev;
		many_on = (channel_light_on[0] & channel_light_on[1]) | (channel_light_on[0]
			& channel_light_on[2]) | (channel_light_on[1] & channel_light_on[2]);
		trk_dac = s_q.dac[s_q.trk];
		frozen = s_q.decim[s_q.trk][DECIM_FREEZE];
		mon_val = monitor_level[s_q.mon_sel];
		// 4:1 mirror only exists for the sinking detector; saturate at full scale
		if (s_q.setup[SETUP_SINK] && s_q.setup[SETUP_RATIO4]) begin
			mon_val = (mon_val > (TARGET_MAX >> 2)) ? TARGET_MAX : mon_val << 2;
		end
	end

	// single next-state process: register file, edge capture, loop engine
	always_comb begin
		logic [1:0] ph_len;
		logic [1:0] ph_dec;
		logic [4:0] ph_sz;
		logic up;
		logic hold;
		s_d = s_q;
		ph_len = 2'h0;
		ph_dec = 2'h0;
		ph_sz = 5'h00;
		up = 1'b0;
		hold = 1'b0;
		s_d.on_prev = channel_light_on;
		// register writes
		if (reg_wr) begin
			for (int c = 0; c < 3; c++) begin
				if (reg_addr == OFS_OUT_MODE[c]) s_d.out_mode[c] = reg_wdata;
				if (reg_addr == OFS_TGT_HI[c]) s_d.target[c][12:8] = reg_wdata[4:0];
				if (reg_addr == OFS_TGT_LO[c]) s_d.target[c][7:0] = reg_wdata;
				if (reg_addr == OFS_LP_HI[c]) s_d.target_lp[c][12:8] = reg_wdata[4:0];
				if (reg_addr == OFS_LP_LO[c]) s_d.target_lp[c][7:0] = reg_wdata;
				if (reg_addr == OFS_INTV[c]) s_d.intv[c] = reg_wdata;
				if (reg_addr == OFS_STEPS[c]) s_d.steps[c] = reg_wdata;
				if (reg_addr == OFS_DECIM[c]) s_d.decim[c] = reg_wdata;
				if (reg_addr == OFS_CODE_HI[c]) s_d.host_code[c][9:8] = reg_wdata[1:0];
				if (reg_addr == OFS_CODE_LO[c]) s_d.host_code[c][7:0] = reg_wdata;
			end
			if (reg_addr == OFS_ROUTING) s_d.routing = reg_wdata;
			if (reg_addr == OFS_SETUP) s_d.setup = reg_wdata;
			if (reg_addr == OFS_MISC) s_d.misc = reg_wdata;
		end
		// register reads; unmapped addresses read zero
		if (reg_rd) begin
			s_d.rdata = RESET_BYTE;
			for (int c = 0; c < 3; c++) begin
				if (reg_addr == OFS_OUT_MODE[c]) s_d.rdata = s_q.out_mode[c];
				if (reg_addr == OFS_TGT_HI[c]) s_d.rdata = {3'h0, s_q.target[c][12:8]};
				if (reg_addr == OFS_TGT_LO[c]) s_d.rdata = s_q.target[c][7:0];
				if (reg_addr == OFS_LP_HI[c]) s_d.rdata = {3'h0, s_q.target_lp[c][12:8]};
				if (reg_addr == OFS_LP_LO[c]) s_d.rdata = s_q.target_lp[c][7:0];
				if (reg_addr == OFS_INTV[c]) s_d.rdata = s_q.intv[c];
				if (reg_addr == OFS_STEPS[c]) s_d.rdata = s_q.steps[c];
				if (reg_addr == OFS_DECIM[c]) s_d.rdata = s_q.decim[c];
				if (reg_addr == OFS_CODE_HI[c]) s_d.rdata = {6'h00, s_q.host_code[c][9:8]};
				if (reg_addr == OFS_CODE_LO[c]) s_d.rdata = s_q.host_code[c][7:0];
				if (reg_addr == OFS_RB_HI[c]) s_d.rdata = {6'h00, s_q.readback[c][9:8]};
				if (reg_addr == OFS_RB_LO[c]) s_d.rdata = s_q.readback[c][7:0];
			end
			if (reg_addr == OFS_ROUTING) s_d.rdata = s_q.routing;
			if (reg_addr == OFS_SETUP) s_d.rdata = s_q.setup;
			if (reg_addr == OFS_MISC) s_d.rdata = s_q.misc;
		end
		// readback snapshot of the live drive codes
		if (reg_wr && reg_addr == OFS_STROBE && reg_wdata[STROBE_RB]) begin
			s_d.readback = s_q.dac;
		end
		// open-loop channels follow the host code
		for (int c = 0; c < 3; c++) begin
			if (!closed(s_q, 2'(c))) s_d.dac[c] = s_q.host_code[c];
		end
		// target choice follows the low-power pin while tracking
		if (s_q.misc[MISC_PIN_LSB +: 2] == PIN_MODE_LOW_POWER && !low_power_select_pin) begin
			s_d.tgt_act = s_q.target_lp[s_q.trk];
		end else begin
			s_d.tgt_act = s_q.target[s_q.trk];
		end
		// loop engine on the tracked channel
		unique case (s_q.st)
			ST_IDLE: begin
			end
			ST_DELAY: begin
				if (!channel_light_on[s_q.trk]) begin
					s_d.st = ST_IDLE;
				end else if (s_q.timer == 16'h0000) begin
					s_d.st = ST_RUN;
					s_d.timer = apcl_period(s_q.intv[s_q.trk][INTV_INIT_LSB +: 2],
						s_q.steps[s_q.trk][STEPS_DIV_LSB +: 2], 2'h0,
						s_q.decim[s_q.trk][DECIM_WAIT_LSB +: 2]);
				end else begin
					s_d.timer = s_q.timer - 16'h0001;
				end
			end
			ST_RUN: begin
				// freeze and overlap both hold the code where it is
				hold = frozen || many_on;
				if (!channel_light_on[s_q.trk]) begin
					s_d.st = ST_IDLE; // code left as reached for the next start
				end else if (hold) begin
				end else if (s_q.timer != 16'h0000) begin
					s_d.timer = s_q.timer - 16'h0001;
				end else begin
					unique case (s_q.phase)
						PHASE_INIT: begin
							ph_sz = {1'b0, s_q.steps[s_q.trk][STEPS_INIT_LSB +: 2], 2'h0} + 5'h04;
							ph_len = s_q.intv[s_q.trk][INTV_INIT_LSB +: 2];
						end
						PHASE_MID: begin
							ph_sz = {3'h0, s_q.steps[s_q.trk][STEPS_MID_LSB +: 2]} + 5'h02;
							ph_len = s_q.intv[s_q.trk][INTV_MID_LSB +: 2];
							ph_dec = s_q.decim[s_q.trk][DECIM_FACTOR_LSB +: 2];
						end
						default: begin
							ph_sz = 5'h01;
							ph_len = s_q.intv[s_q.trk][INTV_MIN_LSB +: 2];
							ph_dec = s_q.decim[s_q.trk][DECIM_FACTOR_LSB +: 2];
						end
					endcase
					up = (mon_val < s_q.tgt_act) ^ s_q.misc[MISC_INVERT];
					if (mon_val != s_q.tgt_act) begin
						s_d.dac[s_q.trk] = apcl_step(trk_dac, ph_sz, up);
					end
					// wait states are folded into each interval reload
					s_d.timer = apcl_period(ph_len, s_q.steps[s_q.trk][STEPS_DIV_LSB +: 2],
						ph_dec, s_q.decim[s_q.trk][DECIM_WAIT_LSB +: 2]);
					if (s_q.nstep == PHASE_STEPS - 4'h1 && s_q.phase != PHASE_MIN) begin
						s_d.nstep = 4'h0;
						s_d.phase = s_q.phase + 2'h1;
					end else if (s_q.phase != PHASE_MIN) begin
						s_d.nstep = s_q.nstep + 4'h1;
					end
				end
			end
			default: s_d.st = ST_IDLE;
		endcase
		// a rising edge retargets the engine; highest index wins a tie
		for (int c = 0; c < 3; c++) begin
			if (rise[c]) begin
				s_d.trk = 2'(c);
				s_d.mon_sel = s_q.routing[2*c +: 2];
				s_d.tgt_act = (s_q.misc[MISC_PIN_LSB +: 2] == PIN_MODE_LOW_POWER
					&& !low_power_select_pin) ? s_q.target_lp[c] : s_q.target[c];
				s_d.phase = PHASE_INIT;
				s_d.nstep = 4'h0;
				if (closed(s_q, 2'(c))) begin
					s_d.st = ST_DELAY;
					s_d.timer = 16'(s_q.decim[c][DECIM_DELAY_LSB +: 2] * DELAY_UNIT_CYC);
					if (s_q.steps[c][STEPS_START_LSB +: 2] == START_ZERO) begin
						s_d.dac[c] = 10'h000;
					end else if (s_q.steps[c][STEPS_START_LSB +: 2] == START_HOST) begin
						s_d.dac[c] = s_q.host_code[c];
					end
				end else begin
					s_d.st = ST_IDLE;
				end
			end
		end
	end

	// state register, synchronous active-low reset
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign drive_code = s_q.dac;
	assign target_active = s_q.tgt_act;
	assign monitor_select = s_q.mon_sel;

	AST_FREEZE_HOLDS: assert property (@(posedge core_clk) disable iff (!rst_n)
		(s_q.st == ST_RUN && frozen && rise == 3'h0 && !reg_wr) |=> $stable(trk_dac))
		else $error("frozen channel code changed");
	AST_OVERLAP_HOLDS: assert property (@(posedge core_clk) disable iff (!rst_n)
		(s_q.st == ST_RUN && many_on && rise == 3'h0 && !reg_wr) |=> $stable(trk_dac))
		else $error("code changed while several lights on");
	AST_OPEN_LOOP: assert property (@(posedge core_clk) disable iff (!rst_n)
		!closed(s_q, 2'h0) |=> s_q.dac[0] == $past(s_q.host_code[0]))
		else $error("open-loop channel not on host code");
	AST_LAST_TRACKED: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rise[1] && !rise[2]) |=> s_q.trk == 2'h1)
		else $error("latest rising channel not tracked");
	AST_ROUTE_ON_RISE: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rise == 3'h1) |=> s_q.mon_sel == $past(s_q.routing[1:0]))
		else $error("monitor route not taken on rise");
	AST_READBACK: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == OFS_STROBE && reg_wdata[STROBE_RB]) |=>
		s_q.readback == $past(s_q.dac))
		else $error("readback not captured");
	AST_DELAY_FIRST: assert property (@(posedge core_clk) disable iff (!rst_n)
		(rise[0] && rise[2:1] == 2'h0 && closed(s_q, 2'h0)) |=> s_q.st == ST_DELAY
		##1 (s_q.st != ST_RUN || $past(s_q.timer) == 16'h0000))
		else $error("loop ran before turn-on delay");
	AST_TARGET_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n)
		(reg_wr && reg_addr == OFS_TGT_HI[0]) |=> s_q.target[0][12:8] == $past(reg_wdata[4:0]))
		else $error("target high byte not stored");
	AST_STEP_UP: assert property (@(posedge core_clk) disable iff (!rst_n)
		(s_q.st == ST_RUN && !frozen && !many_on && s_q.timer == 16'h0000 && rise == 3'h0
		&& channel_light_on[s_q.trk] && !s_q.misc[MISC_INVERT] && mon_val < s_q.tgt_act
		&& trk_dac != DAC_MAX && !reg_wr) |=> trk_dac > $past(trk_dac))
		else $error("code not raised below target");
endmodule : apcl_loop

// ---- verif/apcl_light_drv.sv ----
`timescale 1ns/1ps
// display controller side: raises and drops the light turn-on pins
module apcl_light_drv (
	input wire logic core_clk,
	output logic [2:0] channel_light_on
);
	realtime last_rise = -1000.0; // time of the most recent rising edge on any pin

	initial channel_light_on = 3'h0;

	// rising edges on any two pins are kept at least 500 ns apart
	task automatic rise(input int c);
		while ($realtime - last_rise < 500.0) @(posedge core_clk);
		@(posedge core_clk);
		channel_light_on[c] <= 1'b1;
		last_rise = $realtime;
	endtask : rise

	// falling edges carry no spacing demand
	task automatic fall(input int c);
		@(posedge core_clk);
		channel_light_on[c] <= 1'b0;
	endtask : fall
endmodule : apcl_light_drv

// ---- verif/automatic_power_control_loop_tb.sv ----
`timescale 1ns/1ps
module automatic_power_control_loop_tb;
	import apcl_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr; // set from the seed before reset ends
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [2:0] channel_light_on;
	logic low_power_select_pin = 1'b1; // high picks the normal target
	logic [2:0][12:0] monitor_level;
	logic [2:0][9:0] drive_code;
	logic [12:0] target_active;
	logic [1:0] monitor_select;
	int n_fail = 0;
	int n_compared = 0;
	int seed = 32'he59dc964;
	int mdl [256]; // byte image of what the host wrote
	logic [7:0] d;
	logic [7:0] h;
	logic [9:0] s;
	logic [12:0] r;

	always #4 core_clk = ~core_clk;

	apcl_loop uut (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.channel_light_on(channel_light_on), .low_power_select_pin(low_power_select_pin),
		.monitor_level(monitor_level), .drive_code(drive_code),
		.target_active(target_active), .monitor_select(monitor_select));
	apcl_light_drv drv (.core_clk(core_clk), .channel_light_on(channel_light_on));

	task end_of_test;
		if (n_fail == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// one-cycle write strobe, model image kept alongside
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		mdl[a] = v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data is registered, so look one edge later
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		#1 v = reg_rdata;
	endtask : rd

	// one on-period of channel 0; kind 0 up, 1 down, 2 zero, 3 held, 4 host code
	task automatic run(input logic [12:0] mon, input logic [12:0] tgt, input int kind);
		logic [9:0] c;
		wr(8'h35, 8'h10);
		wr(8'h36, 8'h00); // target 1000h before the pin rises
		monitor_level <= {mon, ~mon, ~mon}; // wrong inputs sit on the other side
		drv.rise(0);
		repeat (3) @(posedge core_clk);
		#1 c = drive_code[0];
		cmp(16'(monitor_select), 16'h0002);
		cmp(16'(target_active), 16'(tgt));
		repeat (80) @(posedge core_clk);
		#1;
		case (kind)
			0: cmp(16'(drive_code[0] > 10'h100), 16'h0001);
			1: cmp(16'(drive_code[0] < 10'h100), 16'h0001);
			2: cmp(16'(drive_code[0]), 16'h0000);
			3: cmp(16'(drive_code[0]), 16'(c));
			default: cmp(16'(drive_code[0]), 16'h0100);
		endcase
		drv.fall(0);
		repeat (2) @(posedge core_clk);
	endtask : run

	// hang guard, far beyond the expected run length
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		end_of_test();
	end

	initial begin
		// idle bus carries random address and data, strobes stay low
		reg_addr <= 8'($random(seed));
		reg_wdata <= 8'($random(seed));
		monitor_level <= '0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		// byte split of the target and refused places
		wr(8'h35, 8'hFF);
		rd(8'h35, d);
		cmp(16'(d), 16'(mdl[8'h35] & 8'h1F));
		rd(8'hF0, d);
		cmp(16'(d), 16'h0000);
		wr(8'h51, 8'hAA);
		rd(8'h51, d);
		cmp(16'(d), 16'h0000);
		for (int i = 0; i < 3; i++) begin
			wr(OFS_TGT_LO[i], 8'($random(seed)));
			rd(OFS_TGT_LO[i], d);
			cmp(16'(d), 16'(mdl[OFS_TGT_LO[i]]));
		end
		// channel 2 left open loop follows its host code
		wr(8'h18, 8'h03);
		wr(8'h19, 8'hAB);
		repeat (3) @(posedge core_clk);
		#1 cmp(16'(drive_code[2]), 16'h03AB);
		// channel 0 closed, fed from input 2, starting at host code 100h
		wr(8'h05, 8'h80);
		wr(8'h34, 8'h46);
		wr(8'h4B, 8'h07);
		wr(8'h48, 8'h04);
		wr(8'h10, 8'h01);
		wr(8'h11, 8'h00);
		r = 13'($random(seed)) & 13'h0FFF;
		run(r, 13'h1000, 0);
		r = 13'h1001 + (13'($random(seed)) & 13'h0FFE);
		run(r, 13'h1000, 1);
		wr(8'h4B, 8'h17);
		run(13'h0400, 13'h1000, 1);
		wr(8'h4A, 8'h30);
		// invert still set: only the 4:1 scaling lifts 600h above target
		run(13'h0600, 13'h1000, 0);
		wr(8'h4A, 8'h00);
		wr(8'h4B, 8'h47);
		wr(8'h3B, 8'h05);
		wr(8'h3C, 8'h55);
		low_power_select_pin <= 1'b0;
		run(13'h0200, 13'h0555, 0);
		low_power_select_pin <= 1'b1;
		wr(8'h4B, 8'h07);
		wr(8'h48, 8'h00);
		run(13'h1800, 13'h1000, 2);
		wr(8'h48, 8'h04);
		// one delay unit outlasts the whole check window, code stays at start
		wr(8'h49, 8'h02);
		run(13'h0300, 13'h1000, 3);
		wr(8'h49, 8'h01);
		run(13'h0300, 13'h1000, 3);
		wr(8'h49, 8'h00);
		wr(8'h34, 8'h06);
		run(13'h0300, 13'h1000, 4);
		wr(8'h34, 8'h46);
		// channel 1 closed loop, starting from host code 100h
		wr(8'h14, 8'h01);
		wr(8'h15, 8'h00);
		wr(8'h45, 8'h04);
		wr(8'h06, 8'h80);
		// overlap: channel 1 rises last and is tracked, updates held
		monitor_level <= {13'h0100, 13'h1F00, 13'h1F00};
		drv.rise(0);
		drv.rise(1);
		repeat (3) @(posedge core_clk);
		#1 s = drive_code[0];
		cmp(16'(monitor_select), 16'h0001);
		repeat (40) @(posedge core_clk);
		#1 cmp(16'(drive_code[0]), 16'(s));
		cmp(16'(drive_code[1]), 16'h0100);
		drv.fall(1);
		drv.fall(0);
		// readback capture of the held code
		repeat (4) @(posedge core_clk);
		#1 s = drive_code[0];
		wr(8'h4C, 8'h02);
		rd(8'h50, h);
		rd(8'h51, d);
		cmp({6'h00, h[1:0], d}, 16'(s));
		end_of_test();
	end
endmodule : automatic_power_control_loop_tb
